// file: hdl/sdmacs_top.sv
// Serial DMA configuration, event and fault address registers on AXI4-Lite.
// How it works
// - 16-bit config register, privileged access only, zero after reset.
// - Freeze code 00 ignores freeze, 10 freezes, 01 and 11 reserved.
// - With freeze selected, bus request drops while freeze input is high.
// - Bus request drops while service level exceeds the programmed mask.
// - Arbitration field gives all channels one shared priority, 0 lowest.
// - Bus error while owning bus always flags; request only if enabled.
// - Breakpoint while owning bus always flags; request only if enabled.
// - Event requests also need the comm processor serial DMA mask bit.
// - 8-bit event register sets on events regardless of enables.
// - Event bits clear on written one, keep on zero, reset clears all.
// - Bus error flag is bit 1 and captures the faulting address.
// - Breakpoint flag is bit 0, set by breakpoint during transfer.
// - Factory test flag clears on written one; bits 7 to 3 reserved.
// - 32-bit read-only fault address register holds the error address.
`timescale 1ns/1ps
`default_nettype none
module sdmacs_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic dma_bus_request_in,
    input wire logic dma_owns_bus,
    input wire logic freeze_in,
    input wire logic [2:0] imb_service_level,
    input wire logic bus_error_pulse,
    input wire logic [31:0] bus_error_addr,
    input wire logic breakpoint_pulse,
    input wire logic factory_test_pulse,
    input wire logic cp_serial_dma_channel_irq_mask,
    output logic bus_request_line,
    output logic [2:0] serial_dma_channel_arb_id,
    output logic serial_dma_channel_irq_req,
    output logic irq
);
    logic [15:0] config_q;
    logic [7:0] event_q;
    logic [31:0] fault_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic aw_priv_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic bus_request_q;
    logic [2:0] arb_id_q;
    logic serial_dma_channel_irq_q;
    logic irq_q;
    logic wr_fire;
    logic rd_fire;
    logic wr_ok;
    logic [7:0] evt_vec;
    logic [7:0] evt_clr;
    logic [7:0] stat_clr;
    logic [1:0] freeze_action;
    logic [2:0] irq_service_mask;
    logic freeze_hold;
    logic level_hold;
    logic [31:0] cfg_merged;
    logic [31:0] mask_merged;

    // Merges written bytes into a register image under the byte strobes.
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Tells whether an address is mapped and may be reached at this level.
    function automatic logic addr_ok(input logic [7:0] a, input logic priv);
        logic ok;
        ok = 1'b0;
        case (a)
            sdmacs_pkg::ADDR_CONFIG: ok = priv;
            sdmacs_pkg::ADDR_EVENT: ok = 1'b1;
            sdmacs_pkg::ADDR_FAULT: ok = 1'b1;
            sdmacs_pkg::ADDR_IRQ_STAT: ok = 1'b1;
            sdmacs_pkg::ADDR_IRQ_MASK: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    assign freeze_action = config_q[sdmacs_pkg::FRZ_LSB +: 2];
    assign irq_service_mask = config_q[sdmacs_pkg::IRQ_SERVICE_MASK_LSB +: 3];
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign rd_fire = arvalid && arready_q;
    assign wr_ok = addr_ok(aw_addr_q, aw_priv_q);
    assign cfg_merged = strb_merge({16'h0000, config_q}, w_data_q,
        w_strb_q);
    assign mask_merged = strb_merge({24'h000000, irq_mask_q}, w_data_q,
        w_strb_q);

    // Bus error and breakpoint events only count while a serial DMA channel owns the bus.
    always_comb
    begin
        evt_vec = sdmacs_pkg::EVT_RESET;
        evt_vec[sdmacs_pkg::EVT_BKP] = breakpoint_pulse && dma_owns_bus;
        evt_vec[sdmacs_pkg::EVT_BERR] = bus_error_pulse && dma_owns_bus;
        evt_vec[sdmacs_pkg::EVT_FTEST] = factory_test_pulse;
    end

    always_comb
    begin
        evt_clr = sdmacs_pkg::EVT_RESET;
        if (wr_fire && aw_addr_q == sdmacs_pkg::ADDR_EVENT && w_strb_q[0])
        begin
            evt_clr = w_data_q[7:0] & sdmacs_pkg::EVT_MASK;
        end
    end

    always_comb
    begin
        stat_clr = sdmacs_pkg::EVT_RESET;
        if (rd_fire && araddr == sdmacs_pkg::ADDR_IRQ_STAT)
        begin
            stat_clr = sdmacs_pkg::EVT_MASK;
        end
    end

    // Reserved codes of the freeze field act like ignore.
    assign freeze_hold = freeze_in && freeze_action == sdmacs_pkg::FRZ_FREEZE;
    assign level_hold = imb_service_level > irq_service_mask;

    // Write address and data channels are taken in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            awready_q <= 1'b0;
            aw_addr_q <= 8'h00;
            aw_priv_q <= 1'b0;
        end
        else if (awvalid && awready_q)
        begin
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= awaddr;
            aw_priv_q <= awprot[0];
        end
        else if (bvalid_q && bready)
        begin
            aw_have_q <= 1'b0;
            awready_q <= 1'b1;
        end
        else if (!aw_have_q)
        begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_q <= 1'b0;
            wready_q <= 1'b0;
            w_data_q <= sdmacs_pkg::RDATA_ZERO;
            w_strb_q <= 4'h0;
        end
        else if (wvalid && wready_q)
        begin
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
        else if (bvalid_q && bready)
        begin
            w_have_q <= 1'b0;
            wready_q <= 1'b1;
        end
        else if (!w_have_q)
        begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= sdmacs_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? sdmacs_pkg::RESP_OKAY : sdmacs_pkg::RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // Only the documented field bits store; the rest stay zero.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            config_q <= sdmacs_pkg::CFG_RESET;
        end
        else if (wr_fire && wr_ok && aw_addr_q == sdmacs_pkg::ADDR_CONFIG)
        begin
            config_q <= cfg_merged[sdmacs_pkg::CFG_W-1:0]
                & sdmacs_pkg::CFG_WR_MASK;
        end
    end

    // A new event in the cycle of its clear wins over the clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            event_q <= sdmacs_pkg::EVT_RESET;
        end
        else
        begin
            event_q <= (event_q & ~evt_clr) | evt_vec;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_q <= sdmacs_pkg::FLT_RESET;
        end
        else if (evt_vec[sdmacs_pkg::EVT_BERR])
        begin
            fault_q <= bus_error_addr;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_q <= sdmacs_pkg::EVT_RESET;
            irq_mask_q <= sdmacs_pkg::EVT_RESET;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~stat_clr) | evt_vec;
            if (wr_fire && aw_addr_q == sdmacs_pkg::ADDR_IRQ_MASK)
            begin
                irq_mask_q <= mask_merged[sdmacs_pkg::EVT_W-1:0]
                    & sdmacs_pkg::EVT_MASK;
            end
        end
    end

    // Read data is latched at the address handshake, so it is stable.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= sdmacs_pkg::RDATA_ZERO;
            rresp_q <= sdmacs_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= addr_ok(araddr, arprot[0]) ? sdmacs_pkg::RESP_OKAY
                : sdmacs_pkg::RESP_SLVERR;
            rdata_q <= sdmacs_pkg::RDATA_ZERO;
            case (araddr)
                sdmacs_pkg::ADDR_CONFIG:
                begin
                    if (arprot[0])
                    begin
                        rdata_q <= {16'h0000, config_q};
                    end
                end
                sdmacs_pkg::ADDR_EVENT: rdata_q <= {24'h000000, event_q};
                sdmacs_pkg::ADDR_FAULT: rdata_q <= fault_q;
                sdmacs_pkg::ADDR_IRQ_STAT: rdata_q <= {24'h000000, irq_stat_q};
                sdmacs_pkg::ADDR_IRQ_MASK: rdata_q <= {24'h000000, irq_mask_q};
                default: rdata_q <= sdmacs_pkg::RDATA_ZERO;
            endcase
        end
        else if (rvalid_q && rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
        else if (!rvalid_q)
        begin
            arready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bus_request_q <= 1'b0;
            arb_id_q <= 3'h0;
        end
        else
        begin
            bus_request_q <= dma_bus_request_in && !freeze_hold && !level_hold;
            arb_id_q <= config_q[sdmacs_pkg::SAID_LSB +: 3];
        end
    end

    // The request level follows the flags, so it stays up until cleared.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_dma_channel_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            serial_dma_channel_irq_q <= cp_serial_dma_channel_irq_mask &&
                ((event_q[sdmacs_pkg::EVT_BERR] && config_q[sdmacs_pkg::BUS_ERROR_IRQ_ENABLE_BIT])
                || (event_q[sdmacs_pkg::EVT_BKP] && config_q[sdmacs_pkg::BREAKPOINT_IRQ_ENABLE_BIT]));
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign bus_request_line = bus_request_q;
    assign serial_dma_channel_arb_id = arb_id_q;
    assign serial_dma_channel_irq_req = serial_dma_channel_irq_q;
    assign irq = irq_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_berr;
        bus_error_pulse && dma_owns_bus;
    endsequence
    sequence s_berr_flagged;
        event_q[sdmacs_pkg::EVT_BERR] && irq_stat_q[sdmacs_pkg::EVT_BERR];
    endsequence

    property p_config_reset;
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> config_q == sdmacs_pkg::CFG_RESET;
    endproperty
    a_config_reset: assert property (p_config_reset)
        else $error("Config register not cleared by reset.");

    property p_freeze_drop;
        freeze_in && freeze_action == sdmacs_pkg::FRZ_FREEZE |=> !bus_request_line;
    endproperty
    a_freeze_drop: assert property (p_freeze_drop)
        else $error("Bus request seen while frozen.");

    property p_freeze_ignore;
        dma_bus_request_in && freeze_action == sdmacs_pkg::FRZ_IGNORE
            && !level_hold |=> bus_request_line;
    endproperty
    a_freeze_ignore: assert property (p_freeze_ignore)
        else $error("Bus request lost with freeze ignored.");

    property p_level_drop;
        imb_service_level > irq_service_mask |=> !bus_request_line;
    endproperty
    a_level_drop: assert property (p_level_drop)
        else $error("Bus request above service mask.");

    property p_berr_flag;
        s_berr |=> s_berr_flagged;
    endproperty
    a_berr_flag: assert property (p_berr_flag)
        else $error("Bus error flag not set.");

    property p_bkp_flag;
        breakpoint_pulse && dma_owns_bus |=> event_q[sdmacs_pkg::EVT_BKP];
    endproperty
    a_bkp_flag: assert property (p_bkp_flag)
        else $error("Breakpoint flag not set.");

    property p_irq_gate;
        !cp_serial_dma_channel_irq_mask |=> !serial_dma_channel_irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Event request without processor mask bit.");

    property p_bus_error_irq_enable_req;
        event_q[sdmacs_pkg::EVT_BERR] && config_q[sdmacs_pkg::BUS_ERROR_IRQ_ENABLE_BIT]
            && cp_serial_dma_channel_irq_mask |=> serial_dma_channel_irq_req;
    endproperty
    a_bus_error_irq_enable_req: assert property (p_bus_error_irq_enable_req)
        else $error("Enabled bus error gave no request.");

    property p_w1c;
        evt_clr[sdmacs_pkg::EVT_BKP] && !evt_vec[sdmacs_pkg::EVT_BKP]
            |=> !event_q[sdmacs_pkg::EVT_BKP];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("Written one did not clear event bit.");

    property p_fault_addr;
        s_berr |=> fault_q == $past(bus_error_addr);
    endproperty
    a_fault_addr: assert property (p_fault_addr)
        else $error("Fault address not captured.");

    property p_reserved;
        1'b1 |-> (config_q & ~sdmacs_pkg::CFG_WR_MASK)
            == sdmacs_pkg::CFG_RESET
            && (event_q & ~sdmacs_pkg::EVT_MASK) == sdmacs_pkg::EVT_RESET;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved bit became set.");

    property p_arb_id;
        ##1 1'b1 |-> serial_dma_channel_arb_id == $past(config_q[sdmacs_pkg::SAID_LSB +: 3]);
    endproperty
    a_arb_id: assert property (p_arb_id)
        else $error("Arbitration priority output wrong.");
endmodule
`default_nettype wire

// file: hdl/sdmacs_pkg.sv
// Constants shared by the serial DMA configuration and status block.
package sdmacs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FAULT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
    localparam int CFG_W = 16;
    localparam int EVT_W = 8;
    localparam int FLT_W = 32;
    localparam int FRZ_LSB = 13;
    localparam int IRQ_SERVICE_MASK_LSB = 8;
    localparam int SAID_LSB = 4;
    localparam int BUS_ERROR_IRQ_ENABLE_BIT = 1;
    localparam int BREAKPOINT_IRQ_ENABLE_BIT = 0;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam logic [CFG_W-1:0] CFG_WR_MASK = 16'h6773;
    localparam logic [1:0] FRZ_IGNORE = 2'h0;
    localparam logic [1:0] FRZ_FREEZE = 2'h2;
    localparam int EVT_BKP = 0;
    localparam int EVT_BERR = 1;
    localparam int EVT_FTEST = 2;
    localparam logic [EVT_W-1:0] EVT_RESET = 8'h00;
    localparam logic [EVT_W-1:0] EVT_MASK = 8'h07;
    localparam logic [FLT_W-1:0] FLT_RESET = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage

// file: verif/sdmacs_far_model.sv
// Far-side model: internal bus arbiter granting the serial DMA the bus.
`timescale 1ns/1ps
`default_nettype none
module sdmacs_far_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic bus_request_line,
    input wire logic slow,
    output logic dma_owns_bus
);
    logic [1:0] wait_q;
    // A slow grant stands for a higher master holding the bus for a while.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !bus_request_line)
        begin
            wait_q <= 2'h0;
            dma_owns_bus <= 1'b0;
        end
        else if (slow && wait_q != 2'h3)
        begin
            wait_q <= wait_q + 2'h1;
        end
        else
        begin
            dma_owns_bus <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verif/sdmacs_tb_top.sv
// Self-checking bench for the serial DMA configuration and status block.
`timescale 1ns/1ps
`default_nettype none
module sdmacs_tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, req_in, owns, freeze_action, berr, bkp;
    logic ftest, cpm, brl, irq_req, irq, slow;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot, lvl, arb;
    logic [31:0] wdata, rdata, baddr, a;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [33:0] rexp_q[$];
    string rname_q[$];
    logic [1:0] bexp_q[$];
    int mismatches, compares, seed, f, l;
    logic [31:0] d;

    sdmacs_top i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .dma_bus_request_in(req_in), .dma_owns_bus(owns),
        .freeze_in(freeze_action), .imb_service_level(lvl), .bus_error_pulse(berr),
        .bus_error_addr(baddr), .breakpoint_pulse(bkp),
        .factory_test_pulse(ftest), .cp_serial_dma_channel_irq_mask(cpm),
        .bus_request_line(brl), .serial_dma_channel_arb_id(arb), .serial_dma_channel_irq_req(irq_req),
        .irq(irq));
    sdmacs_far_model i_far (.aclk(aclk), .aresetn(aresetn),
        .bus_request_line(brl), .slow(slow), .dma_owns_bus(owns));

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] e,
                       input logic [33:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic lchk(input string nm, input logic e, input logic g);
        chk(nm, {33'h0, e}, {33'h0, g});
    endtask

    // Results are compared where they appear, in handshake order.
    always @(posedge aclk)
    begin
        if (rvalid && rready)
            chk(rname_q.pop_front(), rexp_q.pop_front(), {rresp, rdata});
        if (bvalid && bready)
            chk("write response", {32'h0, bexp_q.pop_front()}, {32'h0, bresp});
    end

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt,
                      input logic p, input logic [1:0] er);
        @(posedge aclk);
        bexp_q.push_back(er);
        awaddr <= ad;
        awprot <= {2'h0, p};
        awvalid <= 1'b1;
        wdata <= dt;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1'b1)
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] ad, input logic p,
                      input logic [1:0] er, input logic [31:0] ed);
        @(posedge aclk);
        rname_q.push_back(nm);
        rexp_q.push_back({er, ed});
        araddr <= ad;
        arprot <= {2'h0, p};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1'b1)
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        rready <= 1'b0;
    endtask

    // Error and breakpoint pulses only count while the channel owns the bus.
    task automatic pulse(input int which, input logic [31:0] ad);
        while (owns !== 1'b1) @(posedge aclk);
        baddr <= ad;
        if (which == 0) bkp <= 1'b1;
        else if (which == 1) berr <= 1'b1;
        else ftest <= 1'b1;
        @(posedge aclk);
        berr <= 1'b0;
        bkp <= 1'b0;
        ftest <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        $display("watchdog expired");
        final_report();
    end

    initial
    begin
        seed = 32'h094CF05C;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {req_in, freeze_action, berr, bkp, ftest, cpm, slow} = 7'h00;
        {awaddr, araddr, awprot, arprot, lvl} = 25'h0000000;
        {wdata, baddr} = 64'h0000000000000000;
        wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd("config reset", sdmacs_pkg::ADDR_CONFIG, 1, 2'h0, 32'h0);
        rd("event reset", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h0);
        rd("config user", sdmacs_pkg::ADDR_CONFIG, 0, 2'h2, 32'h0);
        rd("unmapped", 8'h14, 1, 2'h2, 32'h0);
        $display("test reset done");
        for (f = 0; f < 4; f++)
        begin
            d = $random(seed);
            wr(sdmacs_pkg::ADDR_CONFIG, d, 1, 2'h0);
            rd("config", sdmacs_pkg::ADDR_CONFIG, 1, 2'h0,
               {16'h0, d[15:0] & sdmacs_pkg::CFG_WR_MASK});
            lchk("arb id", arb === d[6:4], 1'b1);
        end
        wr(sdmacs_pkg::ADDR_CONFIG, 32'hFFFFFFFF, 0, 2'h2);
        rd("config kept", sdmacs_pkg::ADDR_CONFIG, 1, 2'h0,
           {16'h0, d[15:0] & sdmacs_pkg::CFG_WR_MASK});
        $display("test config done");
        req_in <= 1'b1;
        cpm <= 1'b1;
        for (f = 0; f < 4; f++)
        begin
            wr(sdmacs_pkg::ADDR_CONFIG, {17'h0, f[1:0], 13'h0743}, 1, 2'h0);
            freeze_action <= 1'b1;
            repeat (2) @(posedge aclk);
            lchk("request frozen", f != 2, brl);
            freeze_action <= 1'b0;
        end
        repeat (2) @(posedge aclk);
        lchk("request thawed", 1'b1, brl);
        wr(sdmacs_pkg::ADDR_CONFIG, 32'h00000343, 1, 2'h0);
        for (l = 0; l < 8; l++)
        begin
            lvl <= l[2:0];
            repeat (2) @(posedge aclk);
            lchk("request by level", l <= 3, brl);
        end
        lvl <= 3'h0;
        $display("test request done");
        // Software keeps the comm processor stopped while configuring.
        wr(sdmacs_pkg::ADDR_CONFIG, 32'h00000742, 1, 2'h0);
        slow <= 1'b1;
        a = $random(seed);
        pulse(1, a);
        rd("event berr", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h2);
        rd("fault addr", sdmacs_pkg::ADDR_FAULT, 1, 2'h0, a);
        lchk("irq req berr", 1'b1, irq_req);
        cpm <= 1'b0;
        repeat (2) @(posedge aclk);
        lchk("irq req cp mask", 1'b0, irq_req);
        cpm <= 1'b1;
        wr(sdmacs_pkg::ADDR_EVENT, 32'h0, 1, 2'h0);
        rd("event kept", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h2);
        wr(sdmacs_pkg::ADDR_EVENT, 32'hFF, 1, 2'h0);
        rd("event cleared", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h0);
        // Events while another master holds the bus must leave no trace.
        req_in <= 1'b0;
        repeat (3) @(posedge aclk);
        baddr <= ~a;
        bkp <= 1'b1;
        berr <= 1'b1;
        @(posedge aclk);
        bkp <= 1'b0;
        berr <= 1'b0;
        req_in <= 1'b1;
        rd("event no owner", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h0);
        pulse(0, 32'h0);
        rd("event bkp", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h1);
        lchk("irq req bkp off", 1'b0, irq_req);
        wr(sdmacs_pkg::ADDR_CONFIG, 32'h00000743, 1, 2'h0);
        repeat (2) @(posedge aclk);
        lchk("irq req bkp on", 1'b1, irq_req);
        wr(sdmacs_pkg::ADDR_EVENT, 32'h1, 1, 2'h0);
        pulse(2, 32'h0);
        rd("event ftest", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h4);
        wr(sdmacs_pkg::ADDR_EVENT, 32'h4, 1, 2'h0);
        rd("ftest cleared", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h0);
        wr(sdmacs_pkg::ADDR_FAULT, 32'h0, 1, 2'h0);
        rd("fault kept", sdmacs_pkg::ADDR_FAULT, 1, 2'h0, a);
        $display("test events done");
        lchk("irq masked", 1'b0, irq);
        wr(sdmacs_pkg::ADDR_IRQ_MASK, 32'h7, 1, 2'h0);
        repeat (2) @(posedge aclk);
        lchk("irq raised", 1'b1, irq);
        rd("irq status", sdmacs_pkg::ADDR_IRQ_STAT, 1, 2'h0, 32'h7);
        repeat (2) @(posedge aclk);
        lchk("irq cleared", 1'b0, irq);
        rd("status empty", sdmacs_pkg::ADDR_IRQ_STAT, 1, 2'h0, 32'h0);
        $display("test interrupt done");
        pulse(2, 32'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd("event reset 2", sdmacs_pkg::ADDR_EVENT, 1, 2'h0, 32'h0);
        rd("config reset 2", sdmacs_pkg::ADDR_CONFIG, 1, 2'h0, 32'h0);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
